// *** rtl/drive_health_status_indicator.sv ***
// drive health monitor: temperature errors, load throttle, status indicators, parameter reads
//
// Functional notes
// - class 3 error after over-max longer than 5s
// - class 0 error at warning temperature
// - temperature and both limits readable signed 16-bit
// - load over limit limits current to nominal
// - load back below limit restores full current
// - overload and mean load readable signed percentages
// - green and red state indicators show state
// - distinct pattern per operating state group
// - drive comm: off, green, flashing green unconfigured
// - drive comm: flash red recoverable, red fatal
// - both comm indicators alternate during self-test; the drive one stays off while the drive is unpowered
// - network: off, green address, flashing connections
// - network flashing red on timeout until cleared
// - network steady red on duplicate address
`timescale 1ns/10ps
module drive_health_status_indicator #(
   parameter int unsigned OVERTEMP_CYCLES   = health_pkg::OVERTEMP_CYCLES,
   parameter int unsigned BLINK_HALF_CYCLES = health_pkg::BLINK_HALF_CYCLES
) (
   input  wire logic                  clk_sys,
   input  wire logic                  rst_b,
   // monitored values from the sensing and load estimation logic
   input  wire logic signed [15:0]    temp_actual,
   input  wire logic signed [15:0]    temp_warn_limit,
   input  wire logic signed [15:0]    temp_max_limit,
   input  wire logic signed [15:0]    overload_pct,
   input  wire logic signed [15:0]    mean_load_pct,
   input  wire logic                  load_over_limit,
   // operating state and firmware status
   input  wire logic [3:0]            op_state,
   input  wire logic                  firmware_missing,
   input  wire logic                  internal_error,
   // fieldbus status
   input  wire logic                  drive_powered,
   input  wire logic                  drive_configured,
   input  wire logic                  drive_err_recoverable,
   input  wire logic                  drive_err_fatal,
   input  wire logic                  self_test,
   input  wire logic                  ip_assigned,
   input  wire logic                  conn_active,
   input  wire logic                  conn_timeout,
   input  wire logic                  conn_restored,
   input  wire logic                  ip_duplicate,
   // parameter read port
   input  wire logic                  param_rd,
   input  wire logic [15:0]           param_addr,
   output logic [15:0]                param_rdata_q,
   output logic                       param_valid_q,
   output logic                       param_err_q,
   // monitor results
   output logic                       err_class0_q,
   output logic                       err_class3_q,
   output logic                       current_limit_nominal_q,
   // indicators
   output logic                       state_led_green_q,
   output logic                       state_led_red_q,
   output logic                       drive_led_green_q,
   output logic                       drive_led_red_q,
   output logic                       net_led_green_q,
   output logic                       net_led_red_q
);
   localparam int unsigned OTW = $clog2(OVERTEMP_CYCLES + 1);

   // elaboration checks: the hold counter needs at least one cycle and one spare count
   // above it, and every flashing pattern needs two cycles per half period
   if (OVERTEMP_CYCLES < 1) begin
      $error("over-temperature hold must be at least one cycle");
   end
   if (OVERTEMP_CYCLES == 32'hFFFF_FFFF) begin
      $error("over-temperature hold too long for the counter");
   end
   if (BLINK_HALF_CYCLES < 2) begin
      $error("blink half period must be at least two cycles");
   end

   // ---------------------------------------------------------------- temperature
   logic [OTW-1:0] ot_count_q;
   logic [OTW-1:0] ot_count_d;
   logic           err_class0_d;
   logic           err_class3_d;

   // signed compares: limits may be negative in degrees Celsius
   // the counter holds the number of consecutive over-limit edges and stops at the hold
   // time; the error rises on the next over-limit edge, so the excursion has outlasted
   // the hold time, and any sample at or below the max restarts the count
   always_comb begin
      ot_count_d   = '0;
      err_class3_d = 1'b0;
      err_class0_d = (temp_actual >= temp_warn_limit);
      if (temp_actual > temp_max_limit) begin
         if (ot_count_q == OTW'(OVERTEMP_CYCLES)) begin
            ot_count_d   = ot_count_q;
            err_class3_d = 1'b1;
         end else begin
            ot_count_d   = ot_count_q + 1'b1;
         end
      end else begin
         ot_count_d = '0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         ot_count_q   <= '0;
         err_class0_q <= 1'b0;
         err_class3_q <= 1'b0;
      end else begin
         ot_count_q   <= ot_count_d;
         err_class0_q <= err_class0_d;
         err_class3_q <= err_class3_d;
      end
   end

   // ---------------------------------------------------------------- load throttle
   logic limit_d;

   // throttle follows the load flag both ways; no hysteresis beyond the estimator's own
   // one register of delay, so the current limit changes one cycle after the flag
   always_comb begin
      limit_d = current_limit_nominal_q;
      if (load_over_limit) begin
         limit_d = 1'b1;
      end else begin
         limit_d = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         current_limit_nominal_q <= 1'b0;
      end else begin
         current_limit_nominal_q <= limit_d;
      end
   end

   // ---------------------------------------------------------------- parameter reads
   logic [15:0] rdata_d;
   logic        valid_d;
   logic        err_d;

   // one-cycle answer; unmapped offsets return zero with the error flag
   // the signed values go out as raw bits; the master reads them back as signed words
   always_comb begin
      rdata_d = health_pkg::READ_DATA_RESET;
      valid_d = param_rd;
      err_d   = 1'b0;
      if (param_rd) begin
         case (param_addr)
            health_pkg::ADDR_TEMP_ACTUAL:     rdata_d = temp_actual;
            health_pkg::ADDR_TEMP_WARN_LIMIT: rdata_d = temp_warn_limit;
            health_pkg::ADDR_TEMP_MAX_LIMIT:  rdata_d = temp_max_limit;
            health_pkg::ADDR_OVERLOAD_PCT:    rdata_d = overload_pct;
            health_pkg::ADDR_MEAN_LOAD_PCT:   rdata_d = mean_load_pct;
            default:                          err_d   = 1'b1;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         param_rdata_q <= health_pkg::READ_DATA_RESET;
         param_valid_q <= 1'b0;
         param_err_q   <= 1'b0;
      end else begin
         param_rdata_q <= rdata_d;
         param_valid_q <= valid_d;
         param_err_q   <= err_d;
      end
   end

   // ---------------------------------------------------------------- network timeout latch
   logic timeout_hold_q;
   logic timeout_hold_d;

   // a new timeout wins over a restore in the same cycle; only restore or reset clears
   // the latch keeps the network indicator flashing red after the timeout pulse has gone
   always_comb begin
      timeout_hold_d = timeout_hold_q;
      if (conn_restored) begin
         timeout_hold_d = 1'b0;
      end
      if (conn_timeout) begin
         timeout_hold_d = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         timeout_hold_q <= 1'b0;
      end else begin
         timeout_hold_q <= timeout_hold_d;
      end
   end

   // ---------------------------------------------------------------- indicator selection
   health_pkg::led_pattern_t state_pat;
   health_pkg::led_pattern_t drive_pat;
   health_pkg::led_pattern_t net_pat;

   // state indicators: firmware and internal faults override the state machine display;
   // eight groups need eight looks, so both fault cases light the two colours together,
   // steady for an internal fault and with green flashing for missing firmware
   always_comb begin
      state_pat = health_pkg::PAT_OFF;
      if (internal_error) begin
         state_pat = health_pkg::PAT_BOTH;
      end else if (firmware_missing) begin
         state_pat = health_pkg::PAT_RED_GREEN_FLASH;
      end else begin
         case (op_state)
            health_pkg::OP_START,
            health_pkg::OP_NOT_READY:   state_pat = health_pkg::PAT_OFF;
            health_pkg::OP_SW_DISABLED: state_pat = health_pkg::PAT_GREEN_FLASH;
            health_pkg::OP_READY,
            health_pkg::OP_SWITCHED_ON: state_pat = health_pkg::PAT_GREEN;
            health_pkg::OP_ENABLED:     state_pat = health_pkg::PAT_RED_FLASH;
            health_pkg::OP_QUICK_STOP,
            health_pkg::OP_FAULT_REACT: state_pat = health_pkg::PAT_ALTERNATE;
            health_pkg::OP_FAULT:       state_pat = health_pkg::PAT_RED;
            default:                    state_pat = health_pkg::PAT_OFF;
         endcase
      end
   end

   // drive communication indicator: no power darkens it whatever else is flagged
   // a self-test shows before any error so no error hides the test pattern
   always_comb begin
      drive_pat = health_pkg::PAT_OFF;
      if (!drive_powered) begin
         drive_pat = health_pkg::PAT_OFF;
      end else if (self_test) begin
         drive_pat = health_pkg::PAT_ALTERNATE;
      end else if (drive_err_fatal) begin
         drive_pat = health_pkg::PAT_RED;
      end else if (drive_err_recoverable) begin
         drive_pat = health_pkg::PAT_RED_FLASH;
      end else if (!drive_configured) begin
         drive_pat = health_pkg::PAT_GREEN_FLASH;
      end else begin
         drive_pat = health_pkg::PAT_GREEN;
      end
   end

   // network indicator, highest priority first
   always_comb begin
      net_pat = health_pkg::PAT_OFF;
      if (self_test) begin
         net_pat = health_pkg::PAT_ALTERNATE;
      end else if (ip_duplicate) begin
         net_pat = health_pkg::PAT_RED;
      end else if (timeout_hold_q) begin
         net_pat = health_pkg::PAT_RED_FLASH;
      end else if (!ip_assigned) begin
         net_pat = health_pkg::PAT_OFF;
      end else if (conn_active) begin
         net_pat = health_pkg::PAT_GREEN_FLASH;
      end else begin
         net_pat = health_pkg::PAT_GREEN;
      end
   end

   // ---------------------------------------------------------------- indicator drivers
   logic blink_phase;

   // one timer keeps every flashing indicator in phase
   blink_timer #(
      .HALF_CYCLES (BLINK_HALF_CYCLES)
   ) u_blink (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .phase_q (blink_phase)
   );

   led_pattern_drive u_state_led (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .pattern (state_pat),
      .phase   (blink_phase),
      .green_q (state_led_green_q),
      .red_q   (state_led_red_q)
   );

   led_pattern_drive u_drive_led (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .pattern (drive_pat),
      .phase   (blink_phase),
      .green_q (drive_led_green_q),
      .red_q   (drive_led_red_q)
   );

   led_pattern_drive u_net_led (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .pattern (net_pat),
      .phase   (blink_phase),
      .green_q (net_led_green_q),
      .red_q   (net_led_red_q)
   );
endmodule

// *** rtl/health_pkg.sv ***
// package: register offsets, timing constants and indicator enums for the health block
package health_pkg;
   // parameter offsets as printed (16-bit words on the parameter port)
   localparam logic [15:0] ADDR_TEMP_WARN_LIMIT = 16'h100C;
   localparam logic [15:0] ADDR_TEMP_MAX_LIMIT  = 16'h100E;
   localparam logic [15:0] ADDR_TEMP_ACTUAL     = 16'h1C20;
   localparam logic [15:0] ADDR_OVERLOAD_PCT    = 16'h1C32;
   localparam logic [15:0] ADDR_MEAN_LOAD_PCT   = 16'h1C34;

   // clock and timing
   localparam int unsigned CLK_HZ            = 25000000;
   localparam int unsigned OVERTEMP_TIME_S   = 5;
   localparam int unsigned OVERTEMP_CYCLES   = OVERTEMP_TIME_S * CLK_HZ;
   localparam int unsigned BLINK_HALF_MS     = 500;
   localparam int unsigned BLINK_HALF_CYCLES = BLINK_HALF_MS * (CLK_HZ / 1000);

   // reset values
   localparam logic [15:0] READ_DATA_RESET = 16'h0000;

   // operating state groups shown on the state indicators
   typedef enum logic [3:0] {
      OP_START       = 4'h1,
      OP_NOT_READY   = 4'h2,
      OP_SW_DISABLED = 4'h3,
      OP_READY       = 4'h4,
      OP_SWITCHED_ON = 4'h5,
      OP_ENABLED     = 4'h6,
      OP_QUICK_STOP  = 4'h7,
      OP_FAULT_REACT = 4'h8,
      OP_FAULT       = 4'h9
   } op_state_t;

   // indicator drive patterns
   typedef enum logic [2:0] {
      PAT_OFF,
      PAT_GREEN,
      PAT_GREEN_FLASH,
      PAT_RED,
      PAT_RED_FLASH,
      PAT_ALTERNATE,
      PAT_BOTH,
      PAT_RED_GREEN_FLASH
   } led_pattern_t;
endpackage

// *** rtl/blink_timer.sv ***
// blink timer: half-period counter and a toggling phase for all flashing patterns
`timescale 1ns/10ps
module blink_timer #(
   parameter int unsigned HALF_CYCLES = health_pkg::BLINK_HALF_CYCLES
) (
   input  wire logic clk_sys,
   input  wire logic rst_b,
   output logic      phase_q
);
   localparam int unsigned CW = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;

   // elaboration check: one cycle per half period would leave no visible off phase
   if (HALF_CYCLES < 2) begin
      $error("blink half period must be at least two cycles");
   end

   logic [CW-1:0] count_q;
   logic [CW-1:0] count_d;
   logic          phase_d;

   // counter wraps once per half period; phase flips on the wrap
   always_comb begin
      count_d = count_q + 1'b1;
      phase_d = phase_q;
      if (count_q == CW'(HALF_CYCLES - 1)) begin
         count_d = '0;
         phase_d = ~phase_q;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         count_q <= '0;
         phase_q <= 1'b0;
      end else begin
         count_q <= count_d;
         phase_q <= phase_d;
      end
   end
endmodule

// *** rtl/led_pattern_drive.sv ***
// one bicolour indicator: turns a pattern code and blink phase into green/red drives
`timescale 1ns/10ps
module led_pattern_drive (
   input  wire logic                      clk_sys,
   input  wire logic                      rst_b,
   input  wire health_pkg::led_pattern_t  pattern,
   input  wire logic                      phase,
   output logic                           green_q,
   output logic                           red_q
);
   logic green_d;
   logic red_d;

   // flashing and alternating follow the shared phase so all indicators stay in step
   always_comb begin
      green_d = 1'b0;
      red_d   = 1'b0;
      case (pattern)
         health_pkg::PAT_GREEN:       green_d = 1'b1;
         health_pkg::PAT_GREEN_FLASH: green_d = phase;
         health_pkg::PAT_RED:         red_d   = 1'b1;
         health_pkg::PAT_RED_FLASH:   red_d   = phase;
         health_pkg::PAT_ALTERNATE: begin
            green_d = phase;
            red_d   = ~phase;
         end
         health_pkg::PAT_BOTH: begin
            green_d = 1'b1;
            red_d   = 1'b1;
         end
         health_pkg::PAT_RED_GREEN_FLASH: begin
            green_d = phase;
            red_d   = 1'b1;
         end
         default: begin
            green_d = 1'b0;
            red_d   = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         green_q <= 1'b0;
         red_q   <= 1'b0;
      end else begin
         green_q <= green_d;
         red_q   <= red_d;
      end
   end
endmodule

// *** verif/drive_health_asserts.sv ***
// checker: port timing relations of the drive health block
`timescale 1ns/10ps
module drive_health_asserts #(
   parameter int unsigned OVERTEMP_CYCLES = health_pkg::OVERTEMP_CYCLES
) (
   input wire logic               clk_sys,
   input wire logic               rst_b,
   input wire logic signed [15:0] temp_actual,
   input wire logic signed [15:0] temp_warn_limit,
   input wire logic signed [15:0] temp_max_limit,
   input wire logic               load_over_limit,
   input wire logic               self_test,
   input wire logic               drive_powered,
   input wire logic               ip_duplicate,
   input wire logic               param_rd,
   input wire logic [15:0]        param_addr,
   input wire logic [15:0]        param_rdata_q,
   input wire logic               param_valid_q,
   input wire logic               param_err_q,
   input wire logic               err_class0_q,
   input wire logic               err_class3_q,
   input wire logic               current_limit_nominal_q,
   input wire logic               drive_led_green_q,
   input wire logic               drive_led_red_q,
   input wire logic               net_led_green_q,
   input wire logic               net_led_red_q
);
   int unsigned hot_cnt_q;
   int unsigned hot_cnt_d;

   // consecutive over-limit edges; any cool edge restarts the count
   always_comb hot_cnt_d = (temp_actual > temp_max_limit) ? hot_cnt_q + 1 : 0;
   always_ff @(posedge clk_sys) begin
      hot_cnt_q <= rst_b ? hot_cnt_d : 0;
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   AST_RD_ANSWER: assert property (param_rd |=> param_valid_q)
      else $error("read not answered");
   AST_RD_TEMP: assert property (param_rd && param_addr == health_pkg::ADDR_TEMP_ACTUAL
      |=> param_rdata_q == $past(temp_actual) && !param_err_q) else $error("bad temp read");
   AST_WARN: assert property (temp_actual >= temp_warn_limit |=> err_class0_q)
      else $error("warning not raised");
   // the error stands from the edge at which the count passes the hold time, not before
   AST_HOT_LATE: assert property (hot_cnt_q > OVERTEMP_CYCLES |-> err_class3_q)
      else $error("class 3 late");
   AST_HOT_EARLY: assert property (hot_cnt_q <= OVERTEMP_CYCLES |-> !err_class3_q)
      else $error("class 3 early");
   AST_LOAD: assert property ($changed(load_over_limit)
      |=> current_limit_nominal_q == $past(load_over_limit)) else $error("throttle wrong");
   AST_SELFTEST: assert property (self_test && drive_powered
      |=> drive_led_green_q != drive_led_red_q && net_led_green_q != net_led_red_q)
      else $error("self-test pattern wrong");
   AST_NET_DUP: assert property (ip_duplicate && !self_test
      |=> net_led_red_q && !net_led_green_q) else $error("duplicate address not red");
endmodule

bind drive_health_status_indicator drive_health_asserts #(.OVERTEMP_CYCLES(OVERTEMP_CYCLES))
   u_health_chk (.clk_sys, .rst_b, .temp_actual, .temp_warn_limit, .temp_max_limit,
      .load_over_limit, .self_test, .drive_powered, .ip_duplicate, .param_rd, .param_addr,
      .param_rdata_q, .param_valid_q, .param_err_q, .err_class0_q, .err_class3_q,
      .current_limit_nominal_q, .drive_led_green_q, .drive_led_red_q, .net_led_green_q,
      .net_led_red_q);

// *** verif/fieldbus_master_model.sv ***
// fieldbus master model: single parameter reads on the read port
`timescale 1ns/10ps
module fieldbus_master_model (
   input  wire logic        clk_sys,
   input  wire logic [15:0] param_rdata_q,
   input  wire logic        param_valid_q,
   input  wire logic        param_err_q,
   output logic             param_rd,
   output logic [15:0]      param_addr
);
   initial begin
      param_rd = 1'b0;
      param_addr = 16'h0000;
   end

   // one-cycle request; the answer stands only in the next cycle, so take it there
   task automatic read_word(input logic [15:0] addr, output logic [15:0] data,
                            output logic valid, output logic err);
      @(negedge clk_sys);
      param_rd = 1'b1;
      param_addr = addr;
      @(negedge clk_sys);
      data = param_rdata_q;
      valid = param_valid_q;
      err = param_err_q;
      param_rd = 1'b0;
      param_addr = ~addr; // no stale offset left on the port
   endtask
endmodule

// *** verif/testbench.sv ***
// testbench: random and corner stimulus with self-checks for the health block
`timescale 1ns/10ps
module testbench;
   localparam int unsigned HOT_N = 20;
   logic               clk_sys, rst_b, load_over_limit, firmware_missing, internal_error;
   logic               drive_powered, drive_configured, drive_err_recoverable, drive_err_fatal;
   logic               self_test, ip_assigned, conn_active, conn_timeout, conn_restored;
   logic               ip_duplicate, param_rd, param_valid_q, param_err_q, err_class0_q;
   logic               err_class3_q, current_limit_nominal_q, state_led_green_q, state_led_red_q;
   logic               drive_led_green_q, drive_led_red_q, net_led_green_q, net_led_red_q, v, e;
   logic signed [15:0] temp_actual, temp_warn_limit, temp_max_limit, overload_pct, mean_load_pct;
   logic [15:0]        param_addr, param_rdata_q, d;
   logic [15:0]        vals [5];
   logic [15:0]        addrs [6];
   logic [3:0]         op_state;
   int                 errors, tests_run, cycles, seed;

   drive_health_status_indicator #(.OVERTEMP_CYCLES(HOT_N), .BLINK_HALF_CYCLES(4)) dut (
      .clk_sys, .rst_b, .temp_actual, .temp_warn_limit, .temp_max_limit, .overload_pct,
      .mean_load_pct, .load_over_limit, .op_state, .firmware_missing, .internal_error,
      .drive_powered, .drive_configured, .drive_err_recoverable, .drive_err_fatal, .self_test,
      .ip_assigned, .conn_active, .conn_timeout, .conn_restored, .ip_duplicate, .param_rd,
      .param_addr, .param_rdata_q, .param_valid_q, .param_err_q, .err_class0_q, .err_class3_q,
      .current_limit_nominal_q, .state_led_green_q, .state_led_red_q, .drive_led_green_q,
      .drive_led_red_q, .net_led_green_q, .net_led_red_q);
   fieldbus_master_model fm (.clk_sys, .param_rdata_q, .param_valid_q, .param_err_q,
      .param_rd, .param_addr);

   // 25 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // hang guard: the sequence needs well under 3000 cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      if (errors == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      chk_word({15'h0000, got}, {15'h0000, exp});
   endtask

   // on/off sightings per colour: {green on, green off, red on, red off}
   function automatic logic [3:0] sum_of(input health_pkg::led_pattern_t p);
      case (p)
         health_pkg::PAT_GREEN:       return 4'h9;
         health_pkg::PAT_GREEN_FLASH: return 4'hD;
         health_pkg::PAT_RED:         return 4'h6;
         health_pkg::PAT_RED_FLASH:   return 4'h7;
         health_pkg::PAT_ALTERNATE:   return 4'hF;
         health_pkg::PAT_BOTH:        return 4'hA;
         health_pkg::PAT_RED_GREEN_FLASH: return 4'hE;
         default:                     return 4'h5;
      endcase
   endfunction

   function automatic health_pkg::led_pattern_t state_pat(input int s);
      case (s)
         3:       return health_pkg::PAT_GREEN_FLASH;
         4, 5:    return health_pkg::PAT_GREEN;
         6:       return health_pkg::PAT_RED_FLASH;
         7, 8:    return health_pkg::PAT_ALTERNATE;
         9:       return health_pkg::PAT_RED;
         default: return health_pkg::PAT_OFF;
      endcase
   endfunction

   // window covers a full blink period, so flashing shows both on and off
   task automatic leds(input health_pkg::led_pattern_t ps, pd, pn);
      logic [11:0] seen;
      seen = 12'h000;
      repeat (2) @(negedge clk_sys);
      repeat (10) begin
         seen |= {state_led_green_q, ~state_led_green_q, state_led_red_q, ~state_led_red_q,
                  drive_led_green_q, ~drive_led_green_q, drive_led_red_q, ~drive_led_red_q,
                  net_led_green_q, ~net_led_green_q, net_led_red_q, ~net_led_red_q};
         @(negedge clk_sys);
      end
      chk_word({4'h0, seen}, {4'h0, sum_of(ps), sum_of(pd), sum_of(pn)});
   endtask

   // main sequence, inputs driven on falling edges
   initial begin
      seed = 3565;
      rst_b = 1'b0;
      {load_over_limit, firmware_missing, internal_error, drive_err_recoverable, drive_err_fatal,
       self_test, conn_active, conn_timeout, conn_restored, ip_duplicate} = 10'h000;
      {drive_powered, drive_configured, ip_assigned} = 3'h7;
      op_state = 4'h4;
      for (int i = 0; i < 5; i++) begin
         vals[i] = 16'($random(seed));
      end
      {temp_actual, temp_warn_limit, temp_max_limit, overload_pct, mean_load_pct} =
         {vals[0], vals[1], vals[2], vals[3], vals[4]};
      addrs = '{health_pkg::ADDR_TEMP_ACTUAL, health_pkg::ADDR_TEMP_WARN_LIMIT,
                health_pkg::ADDR_TEMP_MAX_LIMIT, health_pkg::ADDR_OVERLOAD_PCT,
                health_pkg::ADDR_MEAN_LOAD_PCT, 16'h1C22};
      repeat (12) @(negedge clk_sys);
      rst_b = 1'b1;
      for (int i = 0; i < 6; i++) begin
         fm.read_word(addrs[i], d, v, e);
         chk_word(d, (i < 5) ? vals[i] : 16'h0000);
         chk_bit(v, 1'b1);
         chk_bit(e, i == 5);
      end
      temp_warn_limit = 16'h0050;
      temp_max_limit = 16'h0064;
      temp_actual = 16'h0050;
      repeat (2) @(negedge clk_sys);
      chk_bit(err_class0_q, 1'b1);
      temp_actual = 16'h004F;
      repeat (2) @(negedge clk_sys);
      chk_bit(err_class0_q, 1'b0);
      // random readings around the warning limit, one compare per reading
      for (int i = 0; i < 20; i++) begin
         temp_actual = 16'h0040 + 16'($random(seed) & 32'h1F);
         @(negedge clk_sys);
         chk_bit(err_class0_q, temp_actual >= temp_warn_limit);
      end
      // an equal reading in mid-run must restart the over-limit time
      temp_actual = 16'h0065;
      repeat (HOT_N) @(negedge clk_sys);
      temp_actual = 16'h0064;
      @(negedge clk_sys);
      temp_actual = 16'h0065;
      repeat (HOT_N) @(negedge clk_sys);
      chk_bit(err_class3_q, 1'b0);
      @(negedge clk_sys);
      chk_bit(err_class3_q, 1'b1);
      temp_actual = 16'h0000;
      load_over_limit = 1'b1;
      repeat (3) @(negedge clk_sys);
      chk_bit(err_class3_q, 1'b0);
      chk_bit(current_limit_nominal_q, 1'b1);
      load_over_limit = 1'b0;
      repeat (2) @(negedge clk_sys);
      chk_bit(current_limit_nominal_q, 1'b0);
      for (int s = 1; s <= 9; s++) begin
         op_state = 4'(s);
         leds(state_pat(s), health_pkg::PAT_GREEN, health_pkg::PAT_GREEN);
      end
      firmware_missing = 1'b1;
      leds(health_pkg::PAT_RED_GREEN_FLASH, health_pkg::PAT_GREEN, health_pkg::PAT_GREEN);
      internal_error = 1'b1;
      leds(health_pkg::PAT_BOTH, health_pkg::PAT_GREEN, health_pkg::PAT_GREEN);
      {internal_error, firmware_missing, drive_powered, ip_assigned} = 4'h0;
      leds(health_pkg::PAT_RED, health_pkg::PAT_OFF, health_pkg::PAT_OFF);
      {drive_powered, drive_configured, conn_active} = 3'h5;
      leds(health_pkg::PAT_RED, health_pkg::PAT_GREEN_FLASH, health_pkg::PAT_OFF);
      {ip_assigned, drive_err_recoverable} = 2'h3;
      leds(health_pkg::PAT_RED, health_pkg::PAT_RED_FLASH, health_pkg::PAT_GREEN_FLASH);
      drive_err_fatal = 1'b1;
      conn_timeout = 1'b1;
      @(negedge clk_sys);
      conn_timeout = 1'b0;
      leds(health_pkg::PAT_RED, health_pkg::PAT_RED, health_pkg::PAT_RED_FLASH);
      self_test = 1'b1;
      leds(health_pkg::PAT_RED, health_pkg::PAT_ALTERNATE, health_pkg::PAT_ALTERNATE);
      {self_test, ip_duplicate} = 2'h1;
      leds(health_pkg::PAT_RED, health_pkg::PAT_RED, health_pkg::PAT_RED);
      ip_duplicate = 1'b0;
      leds(health_pkg::PAT_RED, health_pkg::PAT_RED, health_pkg::PAT_RED_FLASH);
      conn_restored = 1'b1;
      @(negedge clk_sys);
      conn_restored = 1'b0;
      leds(health_pkg::PAT_RED, health_pkg::PAT_RED, health_pkg::PAT_GREEN_FLASH);
      conn_timeout = 1'b1;
      @(negedge clk_sys);
      {conn_timeout, rst_b} = 2'h0;
      repeat (2) @(negedge clk_sys);
      rst_b = 1'b1;
      leds(health_pkg::PAT_RED, health_pkg::PAT_RED, health_pkg::PAT_GREEN_FLASH);
      report_and_stop();
   end
endmodule
